// ==== ctr_pkg.sv ====
// Shared constants, layouts and carrier types of the converter core trim bank.
package ctr_pkg;

    // ---------------------------------------------------------------
    // Widths and counts
    // ---------------------------------------------------------------
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned TIM_W  = 8;
    localparam int unsigned OFF_W  = 12;
    localparam int unsigned RSV_W  = 4;
    localparam int unsigned N_TIM  = 3;
    localparam int unsigned N_OFF  = 4;

    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [11:0] ADDR_TIM_C2_SA = 12'h315;
    localparam logic [11:0] ADDR_TIM_C1_SB = 12'h31A;
    localparam logic [11:0] ADDR_TIM_C2_SB = 12'h31B;
    localparam logic [11:0] ADDR_OFF_C1_DA = 12'h344;
    localparam logic [11:0] ADDR_OFF_C1_DB = 12'h346;
    localparam logic [11:0] ADDR_OFF_C1_SA = 12'h348;
    localparam logic [11:0] ADDR_OFF_C1_SB = 12'h34A;

    // Timing index: 0 second core input a, 1 first core input b, 2 second core input b.
    localparam logic [N_TIM-1:0][11:0] TIM_ADDR =
        {ADDR_TIM_C2_SB, ADDR_TIM_C1_SB, ADDR_TIM_C2_SA};
    // Offset index is {single, input b}: dual a, dual b, single a, single b.
    localparam logic [N_OFF-1:0][11:0] OFF_ADDR =
        {ADDR_OFF_C1_SB, ADDR_OFF_C1_SA, ADDR_OFF_C1_DB, ADDR_OFF_C1_DA};

    // ---------------------------------------------------------------
    // Field layout and reset values
    // ---------------------------------------------------------------
    localparam int unsigned   OFF_VAL_LSB = 0;
    localparam int unsigned   OFF_RSV_LSB = 12;
    localparam logic [7:0]    TIM_RST     = 8'h00;
    localparam logic [15:0]   OFF_RST     = 16'h0000;
    localparam logic [3:0]    RSV_RST     = 4'h0;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic {
        PH_LOAD,
        PH_RUN
    } ctr_phase_t;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } ctr_bus_req_t;

    typedef struct packed {
        logic single;
        logic fg_cal;
        logic input_b;
        logic dual_in_b;
    } ctr_mode_t;

    typedef struct packed {
        logic [N_TIM-1:0][TIM_W-1:0] tim;
        logic [N_OFF-1:0][OFF_W-1:0] off;
    } ctr_fuse_t;

    typedef struct packed {
        logic             c1_tim_vld;
        logic [TIM_W-1:0] c1_tim;
        logic             c2_tim_vld;
        logic [TIM_W-1:0] c2_tim;
        logic             c1_off_vld;
        logic [OFF_W-1:0] c1_off;
    } ctr_trim_out_t;

    typedef struct packed {
        ctr_phase_t                   phase;
        logic [N_TIM-1:0][TIM_W-1:0]  tim;
        logic [N_OFF-1:0][DATA_W-1:0] off;
        logic [DATA_W-1:0]            rdata;
        ctr_trim_out_t                out;
    } ctr_state_t;

    localparam ctr_state_t ST_RST = '{phase: PH_LOAD, default: '0};

endpackage

// ==== ctr_trim_bank.sv ====
// Trim register bank that holds and routes timing trims of two converter cores and offset trims of the first core.
//
// Decided for this implementation: the plain strobed port.

module ctr_trim_bank (
    input  wire logic                        i_clock,
    input  wire logic                        i_rst_b,
    input  wire logic                        i_clk_en,
    input  wire ctr_pkg::ctr_bus_req_t       i_bus,
    output logic [ctr_pkg::DATA_W-1:0]       o_rdata,
    input  wire ctr_pkg::ctr_mode_t          i_mode,
    input  wire ctr_pkg::ctr_fuse_t          i_fuse,
    output ctr_pkg::ctr_trim_out_t           o_trim
);

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------
    logic [ctr_pkg::N_TIM-1:0] tim_hit;
    logic [ctr_pkg::N_OFF-1:0] off_hit;

    genvar g;
    generate
        for (g = 0; g < ctr_pkg::N_OFF; g++) begin : g_dec
            assign off_hit[g] = (i_bus.addr == ctr_pkg::OFF_ADDR[g]);
            if (g < ctr_pkg::N_TIM) begin : g_tim
                assign tim_hit[g] = (i_bus.addr == ctr_pkg::TIM_ADDR[g]);
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    ctr_pkg::ctr_state_t r;
    ctr_pkg::ctr_state_t nxt;

    logic       run;
    logic       c1_in_b;
    logic [1:0] off_sel;

    always_comb begin
        nxt          = r;
        nxt.rdata    = '0;
        run          = (r.phase == ctr_pkg::PH_RUN);
        c1_in_b      = i_mode.single ? i_mode.input_b : i_mode.dual_in_b;
        off_sel      = {i_mode.single, c1_in_b};
        case (r.phase)
            ctr_pkg::PH_LOAD: begin
                // The fuse image is copied once after reset; bus traffic in
                // that cycle is dropped so the fused defaults always land.
                for (int i = 0; i < ctr_pkg::N_TIM; i++) begin
                    nxt.tim[i] = i_fuse.tim[i];
                end
                for (int i = 0; i < ctr_pkg::N_OFF; i++) begin
                    nxt.off[i] = {ctr_pkg::RSV_RST, i_fuse.off[i]};
                end
                nxt.phase = ctr_pkg::PH_RUN;
            end
            ctr_pkg::PH_RUN: begin
                if (i_bus.wr) begin
                    for (int i = 0; i < ctr_pkg::N_TIM; i++) begin
                        if (tim_hit[i]) begin
                            nxt.tim[i] = i_bus.wdata[ctr_pkg::TIM_W-1:0];
                        end
                    end
                    for (int i = 0; i < ctr_pkg::N_OFF; i++) begin
                        if (off_hit[i]) begin
                            nxt.off[i] = i_bus.wdata;
                        end
                    end
                end
                if (i_bus.rd) begin
                    // Unmapped addresses read as zero.
                    for (int i = 0; i < ctr_pkg::N_TIM; i++) begin
                        if (tim_hit[i]) begin
                            nxt.rdata = {8'h00, r.tim[i]};
                        end
                    end
                    for (int i = 0; i < ctr_pkg::N_OFF; i++) begin
                        if (off_hit[i]) begin
                            nxt.rdata = r.off[i];
                        end
                    end
                end
            end
            default: begin
                nxt.phase = ctr_pkg::PH_LOAD;
            end
        endcase

        // Trim routing; values not selected are driven as zero with valid low.
        nxt.out.c1_tim_vld = run && i_mode.fg_cal && i_mode.single && i_mode.input_b;
        nxt.out.c1_tim     = nxt.out.c1_tim_vld ? r.tim[1] : ctr_pkg::TIM_RST;
        nxt.out.c2_tim_vld = run && i_mode.fg_cal && i_mode.single;
        if (!nxt.out.c2_tim_vld) begin
            nxt.out.c2_tim = ctr_pkg::TIM_RST;
        end else if (i_mode.input_b) begin
            nxt.out.c2_tim = r.tim[2];
        end else begin
            nxt.out.c2_tim = r.tim[0];
        end
        nxt.out.c1_off_vld = run && i_mode.fg_cal;
        if (nxt.out.c1_off_vld) begin
            // Index order matches {single, input b}.
            nxt.out.c1_off = r.off[off_sel][ctr_pkg::OFF_W-1:0];
        end else begin
            nxt.out.c1_off = ctr_pkg::OFF_RST[ctr_pkg::OFF_W-1:0];
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            r <= ctr_pkg::ST_RST;
        end else if (i_clk_en) begin
            r <= nxt;
        end
    end

    assign o_rdata = r.rdata;
    assign o_trim  = r.out;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    fuse_load_a: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (r.phase == ctr_pkg::PH_LOAD && i_clk_en)
        |=> (r.tim[1] == $past(i_fuse.tim[1])) && (r.off[3][15:12] == 4'h0)
            && (r.off[3][11:0] == $past(i_fuse.off[3])))
        else $error("Fuse defaults not loaded after reset.");

    c2_tim_ina_a: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (run && i_clk_en && i_mode.fg_cal && i_mode.single && !i_mode.input_b)
        |=> o_trim.c2_tim_vld && (o_trim.c2_tim == $past(r.tim[0])))
        else $error("Second core input a timing trim not routed.");

    c1_tim_inb_a: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (run && i_clk_en && i_mode.fg_cal && i_mode.single && i_mode.input_b)
        |=> o_trim.c1_tim_vld && (o_trim.c1_tim == $past(r.tim[1])))
        else $error("First core input b timing trim not routed.");

    c2_tim_inb_a: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (run && i_clk_en && i_mode.fg_cal && i_mode.single && i_mode.input_b)
        |=> o_trim.c2_tim == $past(r.tim[2]))
        else $error("Second core input b timing trim not routed.");

    off_dual_a_a: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (run && i_clk_en && i_mode.fg_cal && !i_mode.single && !i_mode.dual_in_b)
        |=> o_trim.c1_off == $past(r.off[0][11:0]))
        else $error("Dual mode input a offset not routed.");

    off_dual_b_a: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (run && i_clk_en && i_mode.fg_cal && !i_mode.single && i_mode.dual_in_b)
        |=> o_trim.c1_off == $past(r.off[1][11:0]))
        else $error("Dual mode input b offset not routed.");

    off_single_a_a: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (run && i_clk_en && i_mode.fg_cal && i_mode.single && !i_mode.input_b)
        |=> o_trim.c1_off_vld && (o_trim.c1_off == $past(r.off[2][11:0])))
        else $error("Single mode input a offset not routed.");

    off_single_b_a: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (run && i_clk_en && i_mode.fg_cal && i_mode.single && i_mode.input_b)
        |=> o_trim.c1_off == $past(r.off[3][11:0]))
        else $error("Single mode input b offset not routed.");

    cal_off_idle_a: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (i_clk_en && !i_mode.fg_cal)
        |=> !o_trim.c1_off_vld && !o_trim.c1_tim_vld && !o_trim.c2_tim_vld
            && (o_trim.c1_off == 12'h000) && (o_trim.c2_tim == 8'h00))
        else $error("Trim driven while calibration is off.");

    write_readback_a: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (run && i_clk_en && i_bus.wr && !i_bus.rd && i_bus.addr == 12'h31A)
        ##1 (i_clk_en && i_bus.rd && !i_bus.wr && i_bus.addr == 12'h31A)
        |=> o_rdata == {8'h00, $past(i_bus.wdata[7:0], 2)})
        else $error("Timing trim write not read back.");

    // ---------------------------------------------------------------
    // Phase, clock enable and read data checks
    // ---------------------------------------------------------------
    // Software only ever sees what the bank holds, so every register is checked on both paths.

    load_to_run_a: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (r.phase == ctr_pkg::PH_LOAD && i_clk_en)
        |=> (r.phase == ctr_pkg::PH_RUN) && (o_rdata == 16'h0000))
        else $error("Fuse load edge did not end in the run phase.");

    run_stays_a: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (run && i_clk_en)
        |=> (r.phase == ctr_pkg::PH_RUN))
        else $error("Run phase left without a reset.");

    clk_freeze_a: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (!i_clk_en)
        |=> $stable(o_rdata) && $stable(o_trim) && $stable(r.tim) && $stable(r.off))
        else $error("State moved while the clock enable was low.");

    rdata_idle_a: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (i_clk_en && !i_bus.rd)
        |=> (o_rdata == 16'h0000))
        else $error("Read data stood beyond its cycle.");

    unmapped_rd_a: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (i_clk_en && i_bus.rd && (tim_hit == '0) && (off_hit == '0))
        |=> (o_rdata == 16'h0000))
        else $error("Unmapped read returned data.");

    hold_idle_a: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (run && i_clk_en && !i_bus.wr)
        |=> $stable(r.tim) && $stable(r.off))
        else $error("Trim register changed without a write.");

    rd_tim0_a: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (run && i_clk_en && i_bus.rd && i_bus.addr == ctr_pkg::ADDR_TIM_C2_SA)
        |=> o_rdata == {8'h00, $past(r.tim[0])})
        else $error("Second core input a timing trim read wrong.");

    rd_tim1_a: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (run && i_clk_en && i_bus.rd && i_bus.addr == ctr_pkg::ADDR_TIM_C1_SB)
        |=> o_rdata == {8'h00, $past(r.tim[1])})
        else $error("First core input b timing trim read wrong.");

    rd_tim2_a: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (run && i_clk_en && i_bus.rd && i_bus.addr == ctr_pkg::ADDR_TIM_C2_SB)
        |=> o_rdata == {8'h00, $past(r.tim[2])})
        else $error("Second core input b timing trim read wrong.");

    rd_off0_a: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (run && i_clk_en && i_bus.rd && i_bus.addr == ctr_pkg::ADDR_OFF_C1_DA)
        |=> o_rdata == $past(r.off[0]))
        else $error("Dual input a offset read wrong.");

    rd_off1_a: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (run && i_clk_en && i_bus.rd && i_bus.addr == ctr_pkg::ADDR_OFF_C1_DB)
        |=> o_rdata == $past(r.off[1]))
        else $error("Dual input b offset read wrong.");

    rd_off2_a: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (run && i_clk_en && i_bus.rd && i_bus.addr == ctr_pkg::ADDR_OFF_C1_SA)
        |=> o_rdata == $past(r.off[2]))
        else $error("Single input a offset read wrong.");

    rd_off3_a: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (run && i_clk_en && i_bus.rd && i_bus.addr == ctr_pkg::ADDR_OFF_C1_SB)
        |=> o_rdata == $past(r.off[3]))
        else $error("Single input b offset read wrong.");

    // ---------------------------------------------------------------
    // Write checks
    // ---------------------------------------------------------------
    wr_tim0_a: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (run && i_clk_en && i_bus.wr && i_bus.addr == ctr_pkg::ADDR_TIM_C2_SA)
        |=> r.tim[0] == $past(i_bus.wdata[7:0]))
        else $error("Second core input a timing trim write lost.");

    wr_tim1_a: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (run && i_clk_en && i_bus.wr && i_bus.addr == ctr_pkg::ADDR_TIM_C1_SB)
        |=> r.tim[1] == $past(i_bus.wdata[7:0]))
        else $error("First core input b timing trim write lost.");

    wr_tim2_a: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (run && i_clk_en && i_bus.wr && i_bus.addr == ctr_pkg::ADDR_TIM_C2_SB)
        |=> r.tim[2] == $past(i_bus.wdata[7:0]))
        else $error("Second core input b timing trim write lost.");

    wr_off0_a: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (run && i_clk_en && i_bus.wr && i_bus.addr == ctr_pkg::ADDR_OFF_C1_DA)
        |=> r.off[0] == $past(i_bus.wdata))
        else $error("Dual input a offset write lost.");

    wr_off1_a: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (run && i_clk_en && i_bus.wr && i_bus.addr == ctr_pkg::ADDR_OFF_C1_DB)
        |=> r.off[1] == $past(i_bus.wdata))
        else $error("Dual input b offset write lost.");

    wr_off2_a: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (run && i_clk_en && i_bus.wr && i_bus.addr == ctr_pkg::ADDR_OFF_C1_SA)
        |=> r.off[2] == $past(i_bus.wdata))
        else $error("Single input a offset write lost.");

    wr_off3_a: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (run && i_clk_en && i_bus.wr && i_bus.addr == ctr_pkg::ADDR_OFF_C1_SB)
        |=> r.off[3] == $past(i_bus.wdata))
        else $error("Single input b offset write or reserved bits lost.");

    // ---------------------------------------------------------------
    // Routing checks
    // ---------------------------------------------------------------
    c1_tim_idle_a: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (i_clk_en && !(i_mode.fg_cal && i_mode.single && i_mode.input_b))
        |=> !o_trim.c1_tim_vld && (o_trim.c1_tim == 8'h00))
        else $error("First core timing trim driven outside its mode.");

    c2_tim_dual_a: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (i_clk_en && !i_mode.single)
        |=> !o_trim.c2_tim_vld && (o_trim.c2_tim == 8'h00))
        else $error("Second core timing trim driven in dual mode.");

    c2_tim_vld_a: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (run && i_clk_en && i_mode.fg_cal && i_mode.single)
        |=> o_trim.c2_tim_vld)
        else $error("Second core timing trim not flagged valid.");

    c1_off_vld_a: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (run && i_clk_en && i_mode.fg_cal)
        |=> o_trim.c1_off_vld)
        else $error("First core offset trim not flagged valid.");

endmodule

// ==== ctr_trim_bank_tb.sv ====
// Self-checking testbench of the converter core trim bank: defaults, access and routing.
module ctr_trim_bank_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                    i_clock;
    logic                    i_rst_b;
    logic                    i_clk_en;
    ctr_pkg::ctr_bus_req_t   i_bus;
    logic [15:0]             o_rdata;
    ctr_pkg::ctr_mode_t      i_mode;
    ctr_pkg::ctr_fuse_t      i_fuse;
    ctr_pkg::ctr_trim_out_t  o_trim;
    logic [11:0]             addr_tab [7];
    logic [15:0]             mdl [7];
    logic [15:0]             q;
    logic [15:0]             w;
    int                      n_mismatch;
    int                      cmp_count;

    ctr_trim_bank dut_u (
        .i_clock  (i_clock),
        .i_rst_b  (i_rst_b),
        .i_clk_en (i_clk_en),
        .i_bus    (i_bus),
        .o_rdata  (o_rdata),
        .i_mode   (i_mode),
        .i_fuse   (i_fuse),
        .o_trim   (o_trim)
    );

    initial begin
        i_clock = 1'b0;
        forever #12.5 i_clock = ~i_clock;
    end

    // ---------------------------------------------------------------
    // Bus tasks and comparisons
    // ---------------------------------------------------------------
    task automatic wr_reg(input logic [11:0] a, input logic [15:0] d);
        @(posedge i_clock);
        i_bus.wr    <= 1'b1;
        i_bus.addr  <= a;
        i_bus.wdata <= d;
        @(posedge i_clock);
        i_bus.wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
    task automatic rd_reg(input logic [11:0] a, output logic [15:0] d);
        @(posedge i_clock);
        i_bus.rd   <= 1'b1;
        i_bus.addr <= a;
        @(posedge i_clock);
        i_bus.rd   <= 1'b0;
        #1;
        d = o_rdata;
    endtask

    task automatic cmp_rd(input logic [11:0] a, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected read data at %h: expected %h, seen %h", a, e, g);
        end
    endtask

    task automatic cmp_trim(input ctr_pkg::ctr_trim_out_t e, input ctr_pkg::ctr_trim_out_t g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected o_trim: expected %h, seen %h", e, g);
        end
    endtask

    function automatic ctr_pkg::ctr_trim_out_t exp_trim(input ctr_pkg::ctr_mode_t m);
        ctr_pkg::ctr_trim_out_t e;
        int                     idx;
        e = '0;
        idx = 3 + {m.single, (m.single ? m.input_b : m.dual_in_b)};
        if (m.single && m.fg_cal && m.input_b) begin
            e.c1_tim_vld = 1'b1;
            e.c1_tim     = mdl[1][7:0];
        end
        if (m.single && m.fg_cal) begin
            e.c2_tim_vld = 1'b1;
            e.c2_tim     = m.input_b ? mdl[2][7:0] : mdl[0][7:0];
        end
        if (m.fg_cal) begin
            e.c1_off_vld = 1'b1;
            e.c1_off     = mdl[idx][11:0];
        end
        return e;
    endfunction

    // Applies reset, lets the fuse-load edge pass and checks every register against the fuses.
    task automatic reset_and_check();
        i_rst_b <= 1'b0;
        repeat (20) @(posedge i_clock);
        i_rst_b <= 1'b1;
        repeat (2) @(posedge i_clock);
        for (int k = 0; k < 7; k++) begin
            mdl[k] = (k < 3) ? {8'h00, i_fuse.tim[k]} : {4'h0, i_fuse.off[k-3]};
            rd_reg(addr_tab[k], q);
            cmp_rd(addr_tab[k], mdl[k], q);
        end
        $display("test fuse defaults done");
    endtask

    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Test sequence
    // ---------------------------------------------------------------
    initial begin
        i_rst_b    = 1'b0;
        i_clk_en   = 1'b1;
        i_bus      = '0;
        i_mode     = '0;
        i_fuse.tim = {8'hC3, 8'hB2, 8'hA1};
        i_fuse.off = {12'hD44, 12'hC33, 12'hB22, 12'hA11};
        n_mismatch = 0;
        cmp_count  = 0;
        for (int k = 0; k < 7; k++) begin
            addr_tab[k] = (k < 3) ? ctr_pkg::TIM_ADDR[k] : ctr_pkg::OFF_ADDR[k-3];
        end
        reset_and_check();
        // Upper byte of timing writes must drop; offset bits 15:12 must store.
        for (int k = 0; k < 7; k++) begin
            w = 16'hF5A0 + 16'(k * 16'h0111);
            wr_reg(addr_tab[k], w);
            mdl[k] = (k < 3) ? {8'h00, w[7:0]} : w;
            rd_reg(addr_tab[k], q);
            cmp_rd(addr_tab[k], mdl[k], q);
        end
        wr_reg(12'h316, 16'hFFFF);
        rd_reg(12'h316, q);
        cmp_rd(12'h316, 16'h0000, q);
        $display("test write and read back done");
        // A read straight after a write must see the new value; then the data fall to zero.
        @(posedge i_clock);
        i_bus.wr    <= 1'b1;
        i_bus.addr  <= ctr_pkg::ADDR_TIM_C1_SB;
        i_bus.wdata <= 16'h1234;
        @(posedge i_clock);
        i_bus.wr    <= 1'b0;
        i_bus.rd    <= 1'b1;
        @(posedge i_clock);
        i_bus.rd    <= 1'b0;
        #1;
        mdl[1] = 16'h0034;
        cmp_rd(ctr_pkg::ADDR_TIM_C1_SB, mdl[1], o_rdata);
        @(posedge i_clock);
        #1;
        cmp_rd(ctr_pkg::ADDR_TIM_C1_SB, 16'h0000, o_rdata);
        // A write while the clock enable is low must be dropped.
        @(posedge i_clock);
        i_clk_en <= 1'b0;
        wr_reg(ctr_pkg::ADDR_TIM_C1_SB, 16'h0055);
        i_clk_en <= 1'b1;
        rd_reg(ctr_pkg::ADDR_TIM_C1_SB, q);
        cmp_rd(ctr_pkg::ADDR_TIM_C1_SB, mdl[1], q);
        $display("test back to back and freeze done");
        for (int m = 0; m < 16; m++) begin
            @(posedge i_clock);
            i_mode <= ctr_pkg::ctr_mode_t'(4'(m));
            repeat (2) @(posedge i_clock);
            #1;
            cmp_trim(exp_trim(ctr_pkg::ctr_mode_t'(4'(m))), o_trim);
        end
        $display("test trim routing done");
        reset_and_check();
        finish_test();
    end

    // The whole sequence needs well under a thousand cycles.
    initial begin
        #(25 * 3000);
        n_mismatch++;
        $display("unexpected hang: expected end of tests, seen timeout");
        finish_test();
    end
endmodule
